// ---- sram_pins.sv ----
// pin-level model of a separate read/write port ddr sram with two-word bursts
//
// Operation
// - write data sampled on both strobe edges
// - write select sampled low on main edge
// - write select high: write data ignored
// - byte selects gate each byte per beat
// - read address main edge, write address inverse
// - 22 address bits narrow, 21 wide
// - deselected port address is ignored
// - read data driven on both strobe edges
// - read select sampled low on main edge
// - deselect: finish burst, then release outputs
// - each read returns two consecutive words
// - valid flag marks data, aligned to echoes
// - termination range latched once after each reset
// - accesses start on main strobe edge
// - echo outputs free-run: echo from main strobe, echo_n from inverted inverse strobe
// - pll off gives one-cycle read latency
`timescale 1ns/10ps

module sram_wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  assign in_ready_o = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = mem[s_q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'h1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'h1;
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[s_q.wp] <= in_data_i;
    end
  end
endmodule

module sram_pins #(
  parameter int DATA_W = sram_pins_pkg::DATA_W_NARROW,
  parameter int ADDR_W = sram_pins_pkg::ADDR_W_NARROW,
  parameter int STORE_AW = sram_pins_pkg::ADDR_W_NARROW,
  parameter int FIFO_DEPTH = sram_pins_pkg::WR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // strobes from the controller
  input wire logic strobe_i,
  input wire logic strobe_n_i,
  // port selects and address
  input wire logic write_port_select_n_i,
  input wire logic read_port_select_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // write port
  input wire logic [DATA_W-1:0] d_i,
  input wire logic [DATA_W/sram_pins_pkg::BYTE_W-1:0] byte_write_select_n_i,
  output logic write_ready_o,
  // read port
  output logic [DATA_W-1:0] q_o,
  output logic q_oe_n_o,
  output logic read_valid_flag_o,
  output logic echo_timing_output_o,
  output logic echo_timing_output_n_o,
  // static straps
  input wire logic pll_disable_n_i,
  input wire logic termination_range_select_i,
  output logic termination_range_high_o
);
  localparam int BW = DATA_W / sram_pins_pkg::BYTE_W;
  localparam int FW = ADDR_W + 2 * BW + 2 * DATA_W;

  if (DATA_W % sram_pins_pkg::BYTE_W != 0 || STORE_AW > ADDR_W || STORE_AW < 1) begin : g_chk
    $error("data width must be whole bytes and store depth within address");
  end

  typedef struct packed {
    logic k_meta;
    logic k_sync;
    logic k_prev;
    logic kn_meta;
    logic kn_sync;
    logic kn_prev;
    logic wps_meta;
    logic wps_sync;
    logic rps_meta;
    logic rps_sync;
    logic [ADDR_W-1:0] a_meta;
    logic [ADDR_W-1:0] a_sync;
    logic [DATA_W-1:0] d_meta;
    logic [DATA_W-1:0] d_sync;
    logic [BW-1:0] bws_meta;
    logic [BW-1:0] bws_sync;
    logic pll_meta;
    logic pll_sync;
    logic odt_meta;
    logic odt_sync;
    logic odt_done;
    logic range_high;
    logic wr_pend;
    logic wr_beat1;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_d0;
    logic [BW-1:0] wr_bws0;
    logic rd_v1;
    logic [ADDR_W-1:0] rd_a1;
    logic rd_v2;
    logic [ADDR_W-1:0] rd_a2;
    logic second_pend;
    logic [ADDR_W-1:0] second_addr;
    logic [DATA_W-1:0] q;
    logic q_oe_n;
    logic valid;
    logic echo;
    logic echo_n;
    logic wr_room;
  } state_t;

  state_t s_q, s_d;
  logic [DATA_W-1:0] mem [2**(STORE_AW+1)];
  logic k_rise, kn_rise, emit, fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_in_data, fifo_out_data;
  logic [ADDR_W-1:0] emit_addr, f_addr;
  logic [BW-1:0] f_bws0, f_bws1;
  logic [DATA_W-1:0] f_d0, f_d1;

  assign k_rise = s_q.k_sync & ~s_q.k_prev;
  assign kn_rise = s_q.kn_sync & ~s_q.kn_prev;
  // latency chosen from the synchronised pll strap
  assign emit = k_rise & (s_q.pll_sync ? s_q.rd_v2 : s_q.rd_v1);
  assign emit_addr = s_q.pll_sync ? s_q.rd_a2 : s_q.rd_a1;
  assign fifo_in_valid = k_rise & s_q.wr_beat1;
  assign fifo_in_data = {s_q.wr_addr, s_q.bws_sync, s_q.wr_bws0, s_q.d_sync, s_q.wr_d0};
  assign {f_addr, f_bws1, f_bws0, f_d1, f_d0} = fifo_out_data;
  // the array has one port; a read burst start wins and writes wait
  assign fifo_out_ready = ~emit;

  sram_wr_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    s_d = s_q;
    // two flops on every pin before use
    s_d.k_meta = strobe_i;
    s_d.k_sync = s_q.k_meta;
    s_d.k_prev = s_q.k_sync;
    s_d.kn_meta = strobe_n_i;
    s_d.kn_sync = s_q.kn_meta;
    s_d.kn_prev = s_q.kn_sync;
    s_d.wps_meta = write_port_select_n_i;
    s_d.wps_sync = s_q.wps_meta;
    s_d.rps_meta = read_port_select_n_i;
    s_d.rps_sync = s_q.rps_meta;
    s_d.a_meta = addr_i;
    s_d.a_sync = s_q.a_meta;
    s_d.d_meta = d_i;
    s_d.d_sync = s_q.d_meta;
    s_d.bws_meta = byte_write_select_n_i;
    s_d.bws_sync = s_q.bws_meta;
    s_d.pll_meta = pll_disable_n_i;
    s_d.pll_sync = s_q.pll_meta;
    s_d.odt_meta = termination_range_select_i;
    s_d.odt_sync = s_q.odt_meta;
    // range taken once, after the strap has passed the synchroniser
    if (!s_q.odt_done) begin
      s_d.odt_done = 1'h1;
      s_d.range_high = s_q.odt_sync;
    end
    s_d.wr_room = fifo_in_ready;
    // echoes follow the sampled strobes, same cycle as data and flag
    s_d.echo = s_q.k_sync;
    s_d.echo_n = ~s_q.kn_sync;
    // write capture: select on main edge, address and beat 0 on inverse, beat 1 on next main
    if (kn_rise && s_q.wr_pend) begin
      s_d.wr_pend = 1'h0;
      s_d.wr_beat1 = 1'h1;
      s_d.wr_addr = s_q.a_sync;
      s_d.wr_d0 = s_q.d_sync;
      s_d.wr_bws0 = s_q.bws_sync;
    end
    if (k_rise) begin
      s_d.wr_beat1 = 1'h0;
      s_d.wr_pend = ~s_q.wps_sync;
      // read pipeline; address taken on every main edge, a deselected port only leaves the valid bit low
      s_d.rd_v1 = ~s_q.rps_sync;
      s_d.rd_a1 = s_q.a_sync;
      s_d.rd_v2 = s_q.rd_v1;
      s_d.rd_a2 = s_q.rd_a1;
      if (emit) begin
        s_d.q = mem[{emit_addr[STORE_AW-1:0], 1'h0}];
        s_d.q_oe_n = 1'h0;
        s_d.valid = 1'h1;
        s_d.second_pend = 1'h1;
        s_d.second_addr = emit_addr;
      end else begin
        s_d.valid = 1'h0;
        s_d.q_oe_n = 1'h1;
      end
    end
    if (kn_rise && s_q.second_pend) begin
      s_d.second_pend = 1'h0;
      s_d.q = mem[{s_q.second_addr[STORE_AW-1:0], 1'h1}];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.q_oe_n <= sram_pins_pkg::RST_OE_N;
      s_q.range_high <= sram_pins_pkg::RST_RANGE_HIGH;
      s_q.wps_sync <= 1'h1;
      s_q.rps_sync <= 1'h1;
      s_q.wps_meta <= 1'h1;
      s_q.rps_meta <= 1'h1;
      // inverse strobe idles high; a zero here would fake an edge after reset
      s_q.kn_meta <= 1'h1;
      s_q.kn_sync <= 1'h1;
      s_q.kn_prev <= 1'h1;
      // strap keeps filling its synchroniser so the latch sees the pin, not a reset zero
      s_q.odt_meta <= termination_range_select_i;
      s_q.odt_sync <= s_q.odt_meta;
    end else begin
      s_q <= s_d;
    end
  end

  // buffered writes drain both beats at once; unselected bytes keep their contents
  always_ff @(posedge sys_clk_i) begin
    if (fifo_out_valid && fifo_out_ready) begin
      for (int l = 0; l < BW; l++) begin
        if (!f_bws0[l]) begin
          mem[{f_addr[STORE_AW-1:0], 1'h0}][l*sram_pins_pkg::BYTE_W +: sram_pins_pkg::BYTE_W] <=
            f_d0[l*sram_pins_pkg::BYTE_W +: sram_pins_pkg::BYTE_W];
        end
        if (!f_bws1[l]) begin
          mem[{f_addr[STORE_AW-1:0], 1'h1}][l*sram_pins_pkg::BYTE_W +: sram_pins_pkg::BYTE_W] <=
            f_d1[l*sram_pins_pkg::BYTE_W +: sram_pins_pkg::BYTE_W];
        end
      end
    end
  end

  assign write_ready_o = s_q.wr_room;
  assign q_o = s_q.q;
  assign q_oe_n_o = s_q.q_oe_n;
  assign read_valid_flag_o = s_q.valid;
  assign echo_timing_output_o = s_q.echo;
  assign echo_timing_output_n_o = s_q.echo_n;
  assign termination_range_high_o = s_q.range_high;
endmodule

// ---- sram_pins_pkg.sv ----
// shared constants for the separate-port double-data-rate sram pin logic
package sram_pins_pkg;
  // part geometry (narrow part defaults; wide part is 36 data, 21 address)
  localparam int DATA_W_NARROW = 18;
  localparam int ADDR_W_NARROW = 22;
  localparam int DATA_W_WIDE = 36;
  localparam int ADDR_W_WIDE = 21;
  localparam int BYTE_W = 9;
  localparam int BURST_LEN = 2;
  // read latency in main strobe cycles
  localparam int LAT_PLL_ON = 2;
  localparam int LAT_PLL_OFF = 1;
  // strobe ceiling the controller must keep with the pll off
  localparam int STROBE_MAX_PLL_OFF_MHZ = 167;
  // clock of this model
  localparam int SYS_CLK_MHZ = 40;
  localparam int SYS_CLK_PERIOD_NS = 25;
  // write buffer
  localparam int WR_FIFO_DEPTH = 16;
  // reset values
  localparam logic RST_OE_N = 1'h1;
  localparam logic RST_RANGE_HIGH = 1'h1;
endpackage

// ---- sram_pins_monitor.sv ----
// port assertions for the sram pin model
`timescale 1ns/10ps
module sram_pins_monitor #(
  parameter int DATA_W = 18
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // pins watched
  input wire logic strobe_i,
  input wire logic read_port_select_n_i,
  input wire logic pll_disable_n_i,
  input wire logic [DATA_W-1:0] q_o,
  input wire logic q_oe_n_o,
  input wire logic read_valid_flag_o,
  input wire logic echo_timing_output_o,
  input wire logic termination_range_high_o
);
  // strobe cycles since the last read request, saturating
  logic [2:0] idle_q;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      idle_q <= 3'h0;
    end else if ($rose(strobe_i)) begin
      idle_q <= read_port_select_n_i ? idle_q + 3'(idle_q != 3'h7) : 3'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  sequence rd_req;
    $rose(strobe_i) && !read_port_select_n_i;
  endsequence
  sequence beat0;
    $rose(echo_timing_output_o) && read_valid_flag_o;
  endsequence
  // bounds assume ten sys_clk per strobe cycle
  a_lat_long: assert property (disable iff (!reset_n_i) rd_req and pll_disable_n_i |-> ##[22:26] beat0)
    else $error("read burst late or early with pll on");
  a_lat_short: assert property (disable iff (!reset_n_i) rd_req and !pll_disable_n_i |-> ##[12:16] beat0)
    else $error("read burst late or early with pll off");
  a_reset_state: assert property (!reset_n_i |=> q_oe_n_o && !read_valid_flag_o && termination_range_high_o)
    else $error("outputs not idle in reset");
  a_oe_tracks_valid: assert property (disable iff (!reset_n_i) q_oe_n_o == !read_valid_flag_o)
    else $error("output enable disagrees with valid");
  a_echo_follows: assert property (disable iff (!reset_n_i) $rose(strobe_i) |-> ##[2:5] $rose(echo_timing_output_o))
    else $error("echo did not follow strobe");
  a_valid_on_echo: assert property (disable iff (!reset_n_i) $changed(read_valid_flag_o) |-> $rose(echo_timing_output_o))
    else $error("valid moved off an echo rise");
  a_q_on_edges: assert property (disable iff (!reset_n_i) $changed(q_o) && !q_oe_n_o |-> $changed(echo_timing_output_o))
    else $error("read data moved off an echo edge");
  a_idle_quiet: assert property (disable iff (!reset_n_i) idle_q >= 3'h4 |-> !read_valid_flag_o)
    else $error("read port busy without a request");
  a_range_held: assert property (disable iff (!reset_n_i) $past(reset_n_i, 5) |-> $stable(termination_range_high_o))
    else $error("termination range changed after latch");
endmodule
bind sram_pins sram_pins_monitor #(.DATA_W(DATA_W)) mon (.sys_clk_i, .reset_n_i, .strobe_i, .read_port_select_n_i,
  .pll_disable_n_i, .q_o, .q_oe_n_o, .read_valid_flag_o, .echo_timing_output_o, .termination_range_high_o);

// ---- sram_ctrl_model.sv ----
// controller model driving strobes, selects, address and write beats
`timescale 1ns/10ps
module sram_ctrl_model (
  // clock
  input wire logic clk_i,
  // memory pins
  output logic k_o,
  output logic kn_o,
  output logic ws_n_o,
  output logic rs_n_o,
  output logic [21:0] a_o,
  output logic [17:0] d_o,
  output logic [1:0] bw_n_o
);
  logic wp_q;
  logic [19:0] b1_q;
  initial begin
    {k_o, kn_o, ws_n_o, rs_n_o, wp_q} = 5'h0E;
    {a_o, d_o, bw_n_o} = '0;
  end
  // ten sys_clk per strobe cycle, far under the pll-off ceiling
  task automatic run(input logic rd, input logic [21:0] ra, input logic wr, input logic [21:0] wa,
                     input logic [17:0] w0, input logic [17:0] w1, input logic [3:0] bw);
    @(negedge clk_i);
    {k_o, kn_o} = 2'h2;
    rs_n_o = !rd;
    ws_n_o = !wr;
    a_o = rd ? ra : ~a_o;
    {bw_n_o, d_o} = wp_q ? b1_q : ~{bw_n_o, d_o};
    repeat (5) @(negedge clk_i);
    {k_o, kn_o} = 2'h1;
    a_o = wr ? wa : ~a_o;
    {bw_n_o, d_o} = {bw[1:0], w0};
    {wp_q, b1_q} = {wr, bw[3:2], w1};
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// ---- sep_port_ddr_sram_pins_tb.sv ----
// self-checking bench for the sram pin model
`timescale 1ns/10ps
module sep_port_ddr_sram_pins_tb;
  typedef struct packed {
    logic rd;
    logic [21:0] ra;
    logic wr;
    logic [21:0] wa;
    logic [17:0] w0;
    logic [17:0] w1;
    logic [3:0] bw_n;
  } row_t;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic pll_off_n = 1'h1;
  logic strap = 1'h0;
  logic echo_p = 1'h0;
  logic k, kn, ws_n, rs_n, oe_n, rvalid, echo, echo_n, wready, range_hi;
  logic [21:0] a;
  logic [17:0] d, q;
  logic [1:0] bw_n;
  logic [17:0] mem [512];
  logic [33:0] exp_q[$], got_q[$];
  row_t rows [6];
  int bad_count = 0, samples_checked = 0, calls = 0, ecnt = 0, cycles = 0, lat = 2;
  always #12.5 sys_clk = ~sys_clk;
  sram_ctrl_model ctl (.clk_i(sys_clk), .k_o(k), .kn_o(kn), .ws_n_o(ws_n), .rs_n_o(rs_n), .a_o(a), .d_o(d),
    .bw_n_o(bw_n));
  sram_pins #(.STORE_AW(8)) dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .strobe_i(k), .strobe_n_i(kn),
    .write_port_select_n_i(ws_n), .read_port_select_n_i(rs_n), .addr_i(a), .d_i(d), .byte_write_select_n_i(bw_n),
    .write_ready_o(wready), .q_o(q), .q_oe_n_o(oe_n), .read_valid_flag_o(rvalid), .echo_timing_output_o(echo),
    .echo_timing_output_n_o(echo_n), .pll_disable_n_i(pll_off_n), .termination_range_select_i(strap),
    .termination_range_high_o(range_hi));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [33:0] got, input logic [33:0] want);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // word index is the stored address with the beat appended
  task automatic apply(input row_t r);
    ctl.run(r.rd, r.ra, r.wr, r.wa, r.w0, r.w1, r.bw_n);
    calls++;
    for (int i = 0; i < 4; i++) begin
      if (r.wr && !r.bw_n[i]) mem[{r.wa[7:0], i[1]}][i[0]*9 +: 9] = 9'((i[1] ? r.w1 : r.w0) >> (i[0]*9));
    end
    for (int b = 0; b < 2; b++) begin
      if (r.rd) exp_q.push_back({16'(calls + lat), mem[{r.ra[7:0], b[0]}]});
    end
  endtask
  task automatic drain;
    repeat (3) apply('0);
    while (exp_q.size() > 0) begin
      check(got_q.size() > 0 ? got_q.pop_front() : 34'h0, exp_q.pop_front());
    end
    check(34'(got_q.size()), 34'h0);
  endtask
  // echo rise n marks strobe cycle n, so arrival cycle checks latency
  always @(negedge sys_clk) begin
    if (echo === 1'h1 && echo_p === 1'h0) ecnt++;
    if (echo !== echo_p && rvalid === 1'h1) got_q.push_back({16'(ecnt), q});
    if (echo !== echo_p) check(34'(echo_n), 34'(echo));
    echo_p = echo;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    rows[0] = '{1'h0, 22'h0, 1'h1, 22'h10, 18'h1A5A5, 18'h2C3C3, 4'h0};
    rows[1] = '{1'h0, 22'h0, 1'h1, 22'h20, 18'h0F0F0, 18'h30303, 4'h0};
    rows[2] = '{1'h0, 22'h10, 1'h0, 22'h10, 18'h3FFFF, 18'h3FFFF, 4'h0};
    rows[3] = '{1'h1, 22'h10, 1'h1, 22'h20, 18'h00155, 18'h2AAAA, 4'hA};
    rows[4] = '{1'h1, 22'h10, 1'h0, 22'h0, 18'h0, 18'h0, 4'hF};
    // a buffered write to a burst's address in the next row would land between its two words
    rows[5] = '{1'h1, 22'h20, 1'h1, 22'h20, 18'h3FE00, 18'h1FF00, 4'h5};
    repeat (10) @(negedge sys_clk);
    check(34'({oe_n, rvalid, range_hi}), 34'h5);
    reset_n = 1'h1;
    repeat (6) @(negedge sys_clk);
    check(34'({range_hi, wready}), 34'h1);
    foreach (rows[i]) apply(rows[i]);
    drain();
    pll_off_n = 1'h0;
    lat = 1;
    repeat (4) @(negedge sys_clk);
    apply('{1'h1, 22'h10, 1'h0, 22'h0, 18'h0, 18'h0, 4'hF});
    apply('{1'h1, 22'h20, 1'h0, 22'h0, 18'h0, 18'h0, 4'hF});
    drain();
    // a read cut off by reset must leave no burst behind
    ctl.run(1'h1, 22'h10, 1'h0, 22'h0, 18'h0, 18'h0, 4'hF);
    calls++;
    reset_n = 1'h0;
    // strap moves only while reset holds, so the relatch must take the high range
    strap = 1'h1;
    repeat (10) @(negedge sys_clk);
    check(34'({oe_n, rvalid}), 34'h2);
    reset_n = 1'h1;
    repeat (6) @(negedge sys_clk);
    check(34'(range_hi), 34'h1);
    drain();
    end_sim();
  end
endmodule
